// *** rtl/dlzt_pkg.sv ***
// Package of timing constants, command codes and carriers for the DDR4 timing block.
package dlzt_pkg;

  // ==========================================================
  // Clock rate
  localparam int CLK_PERIOD_PS = 4000;

  // ==========================================================
  // Calibration and power saving counts, in clock cycles
  localparam logic [10:0] ZQ_INIT_NCK = 11'h400;
  localparam logic [10:0] ZQ_LONG_NCK = 11'h200;
  localparam logic [10:0] ZQ_SHORT_NCK = 11'h080;
  localparam logic [10:0] CPDED_NCK = 11'h004;
  localparam logic [10:0] MOD_NCK_DEF = 11'h018;

  // ==========================================================
  // Host-side waits kept here for reference
  localparam int EXIT_PAD_NS = 10;
  localparam int EXIT_PAD_NCK = (EXIT_PAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKSRX_NCK_MIN = 5;

  // ==========================================================
  // Decoded command types
  typedef enum logic [2:0] {
    DLZT_CMD_NOP = 3'h0,
    DLZT_CMD_ZQCL = 3'h1,
    DLZT_CMD_ZQCS = 3'h2,
    DLZT_CMD_MPSM = 3'h3,
    DLZT_CMD_OTHER = 3'h4
  } dlzt_cmd_t;

  // Command as it arrives from the controller.
  typedef struct packed {
    logic cke;
    logic cs_n;
    dlzt_cmd_t cmd;
  } dlzt_req_t;

  // Status presented back to the controller.
  typedef struct packed {
    logic cal_busy;
    logic init_cal;
    logic mpsm;
    logic cmd_path_off;
  } dlzt_stat_t;

endpackage

// *** rtl/dlzt_timer.sv ***
// Device-side tracker of calibration and power saving timing.
// Behaviour
// - After the first CKE high following reset, long calibration runs at least 1024 cycles before results are used.
// - A long calibration command keeps the device busy at least 512 cycles.
// - A short calibration command keeps the device busy at least 128 cycles.
// - Power saving entry disables the command path after update plus disable delay.
// - The command-path disable delay is 4 cycles.
module dlzt_timer #(
  parameter logic [10:0] MOD_NCK = dlzt_pkg::MOD_NCK_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Command from the controller
  input dlzt_pkg::dlzt_req_t req,
  // Status
  output dlzt_pkg::dlzt_stat_t stat
);

  // ==========================================================
  // Calibration state
  typedef enum logic [1:0] {
    DLZT_CAL_INIT = 2'b00,
    DLZT_CAL_IDLE = 2'b01,
    DLZT_CAL_BUSY = 2'b10
  } dlzt_cal_t;

  dlzt_cal_t cal_reg;
  logic [10:0] cal_cnt_reg;
  logic [10:0] mp_cnt_reg;
  logic mp_pend_reg;
  logic mpsm_reg;
  logic path_off_reg;
  logic cke_seen_reg;
  logic cke_last_reg;

  // Commands only count while the path is live and the chip is selected.
  wire logic live = req.cke && !req.cs_n && !path_off_reg;
  wire logic zql = live && (req.cmd == dlzt_pkg::DLZT_CMD_ZQCL);
  wire logic zqs = live && (req.cmd == dlzt_pkg::DLZT_CMD_ZQCS);
  wire logic mpe = live && (req.cmd == dlzt_pkg::DLZT_CMD_MPSM);
  // Exit is a rising CKE while in power saving; chip select must already be low.
  wire logic mpx = path_off_reg && req.cke && !cke_last_reg && !req.cs_n;

  // ==========================================================
  // Calibration timer. Initial calibration starts on the first CKE high
  // after reset, because the device cannot calibrate with CKE still low.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_reg <= DLZT_CAL_INIT;
      cal_cnt_reg <= 11'h000;
      cke_seen_reg <= 1'b0;
    end else begin
      unique case (cal_reg)
        DLZT_CAL_INIT: begin
          if (req.cke) begin
            cke_seen_reg <= 1'b1;
          end
          if (cke_seen_reg) begin
            if (cal_cnt_reg == dlzt_pkg::ZQ_INIT_NCK - 11'h001) begin
              cal_reg <= DLZT_CAL_IDLE;
              cal_cnt_reg <= 11'h000;
            end else begin
              cal_cnt_reg <= cal_cnt_reg + 11'h001;
            end
          end
        end
        DLZT_CAL_IDLE: begin
          if (zql) begin
            cal_reg <= DLZT_CAL_BUSY;
            cal_cnt_reg <= dlzt_pkg::ZQ_LONG_NCK - 11'h001;
          end else if (zqs) begin
            cal_reg <= DLZT_CAL_BUSY;
            cal_cnt_reg <= dlzt_pkg::ZQ_SHORT_NCK - 11'h001;
          end
        end
        DLZT_CAL_BUSY: begin
          // Commands arriving now are ignored; the controller must hold off.
          if (cal_cnt_reg == 11'h001) begin
            cal_reg <= DLZT_CAL_IDLE;
          end
          cal_cnt_reg <= cal_cnt_reg - 11'h001;
        end
        default: begin
          cal_reg <= DLZT_CAL_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Power saving entry and exit. The path stays open for the update delay
  // plus the fixed disable delay, so the entry command itself settles first.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mp_pend_reg <= 1'b0;
      mp_cnt_reg <= 11'h000;
      mpsm_reg <= 1'b0;
      path_off_reg <= 1'b0;
      cke_last_reg <= 1'b0;
    end else begin
      cke_last_reg <= req.cke;
      if (mpe && !mp_pend_reg) begin
        mp_pend_reg <= 1'b1;
        mpsm_reg <= 1'b1;
        mp_cnt_reg <= MOD_NCK + dlzt_pkg::CPDED_NCK - 11'h001;
      end else if (mp_pend_reg) begin
        if (mp_cnt_reg == 11'h001) begin
          mp_pend_reg <= 1'b0;
          path_off_reg <= 1'b1;
        end
        mp_cnt_reg <= mp_cnt_reg - 11'h001;
      end else if (mpx) begin
        path_off_reg <= 1'b0;
        mpsm_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Status outputs, each from a flip-flop.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat.cal_busy <= (cal_reg != DLZT_CAL_IDLE);
      stat.init_cal <= (cal_reg == DLZT_CAL_INIT);
      stat.mpsm <= mpsm_reg;
      stat.cmd_path_off <= path_off_reg;
    end
  end

  // ==========================================================
  // Checks
  // Check-only counters. They run apart from the working counters, so an
  // off-by-one in the working logic cannot hide inside the assertions.
  logic [10:0] chk_init_cnt_reg;
  logic [10:0] chk_busy_cnt_reg;
  logic [10:0] chk_mp_cnt_reg;
  logic chk_long_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chk_init_cnt_reg <= 11'h000;
    end else if (cal_reg == DLZT_CAL_INIT && cke_seen_reg) begin
      chk_init_cnt_reg <= chk_init_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chk_busy_cnt_reg <= 11'h000;
      chk_long_reg <= 1'b0;
    end else if (cal_reg == DLZT_CAL_IDLE && (zql || zqs)) begin
      chk_busy_cnt_reg <= 11'h001;
      chk_long_reg <= zql;
    end else if (cal_reg == DLZT_CAL_BUSY) begin
      chk_busy_cnt_reg <= chk_busy_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chk_mp_cnt_reg <= 11'h000;
    end else if (mpe && !mp_pend_reg) begin
      chk_mp_cnt_reg <= 11'h001;
    end else if (mp_pend_reg) begin
      chk_mp_cnt_reg <= chk_mp_cnt_reg + 11'h001;
    end
  end

  sequence s_zql;
    cal_reg == DLZT_CAL_IDLE && zql;
  endsequence

  sequence s_zqs;
    cal_reg == DLZT_CAL_IDLE && zqs;
  endsequence

  sequence s_init_end;
    cal_reg == DLZT_CAL_INIT ##1 cal_reg == DLZT_CAL_IDLE;
  endsequence

  sequence s_busy_end;
    cal_reg == DLZT_CAL_BUSY ##1 cal_reg == DLZT_CAL_IDLE;
  endsequence

  property p_init_len;
    @(posedge clock) disable iff (rst)
      s_init_end |-> (chk_init_cnt_reg == dlzt_pkg::ZQ_INIT_NCK);
  endproperty
  a_init_len: assert property (p_init_len) else $error("Initial calibration length wrong.");

  property p_long_len;
    @(posedge clock) disable iff (rst)
      s_busy_end |-> (!chk_long_reg || chk_busy_cnt_reg == dlzt_pkg::ZQ_LONG_NCK);
  endproperty
  a_long_len: assert property (p_long_len) else $error("Long calibration length wrong.");

  property p_short_len;
    @(posedge clock) disable iff (rst)
      s_zqs |-> ##127 (cal_reg == DLZT_CAL_BUSY) ##1 (cal_reg == DLZT_CAL_IDLE);
  endproperty
  a_short_len: assert property (p_short_len) else $error("Short calibration length wrong.");

  property p_busy_flag;
    @(posedge clock) disable iff (rst)
      s_zql |-> ##2 stat.cal_busy [*8];
  endproperty
  a_busy_flag: assert property (p_busy_flag) else $error("Busy flag missing during calibration.");

  property p_entry_off;
    @(posedge clock) disable iff (rst)
      $rose(path_off_reg) |-> (chk_mp_cnt_reg == MOD_NCK + dlzt_pkg::CPDED_NCK);
  endproperty
  a_entry_off: assert property (p_entry_off) else $error("Command path disable timing wrong.");

  property p_cpded_min;
    @(posedge clock) disable iff (rst)
      $rose(mp_pend_reg) |-> !path_off_reg [*4];
  endproperty
  a_cpded_min: assert property (p_cpded_min) else $error("Command path closed too early.");

  property p_exit_cs;
    @(posedge clock) disable iff (rst)
      $fell(path_off_reg) |-> !$past(req.cs_n) && $past(req.cke);
  endproperty
  a_exit_cs: assert property (p_exit_cs) else $error("Exit without chip select.");

  property p_stat_mpsm;
    @(posedge clock) disable iff (rst)
      $rose(path_off_reg) |=> stat.cmd_path_off && stat.mpsm;
  endproperty
  a_stat_mpsm: assert property (p_stat_mpsm) else $error("Power saving status wrong.");

endmodule

// *** tb/dlzt_ctrl_model.sv ***
// Controller model that drives CKE, chip select and commands into the timing block.
module dlzt_ctrl_model #(
  parameter int XPR_NCK = 5,
  parameter int XMP_NCK = 8
) (
  // Clock
  input wire logic clock,
  // Command to the device
  output dlzt_pkg::dlzt_req_t req
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Idle state
  // Deselected cycles carry a calibration code, so a device that ignores chip select is caught.
  initial begin
    req = '{cke: 1'b0, cs_n: 1'b1, cmd: dlzt_pkg::DLZT_CMD_ZQCS};
  end

  // ==========================================================
  // Transfers
  // wait after CKE high
  task automatic power_up();
    req.cke = 1'b1;
    repeat (XPR_NCK) @(posedge clock);
    #1;
  endtask

  // One selected command for one cycle, then deselect again.
  task automatic send(input dlzt_pkg::dlzt_cmd_t cmd);
    req.cs_n = 1'b0;
    req.cmd = cmd;
    @(posedge clock);
    #1;
    req.cs_n = 1'b1;
    req.cmd = dlzt_pkg::DLZT_CMD_ZQCS;
  endtask

  // deselected CKE bounce
  // A CKE rise with chip select high must not count as an exit.
  task automatic deselected_bounce();
    req.cke = 1'b0;
    @(posedge clock);
    #1;
    req.cke = 1'b1;
    @(posedge clock);
    #1;
  endtask

  task automatic mpsm_exit();
    req.cs_n = 1'b0;
    req.cmd = dlzt_pkg::DLZT_CMD_NOP;
    req.cke = 1'b0;
    @(posedge clock);
    #1;
    req.cke = 1'b1;
    @(posedge clock);
    #1;
    req.cs_n = 1'b1;
    req.cmd = dlzt_pkg::DLZT_CMD_ZQCS;
    repeat (XMP_NCK) @(posedge clock);
    #1;
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking testbench for the calibration and power saving timing block.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [10:0] MOD = 11'h008;
  logic clock = 1'b0;
  logic rst = 1'b1;
  dlzt_pkg::dlzt_req_t req;
  dlzt_pkg::dlzt_stat_t stat;
  int bad_count = 0;
  int check_count = 0;

  // ==========================================================
  // Clock and instances
  // A short mode update delay keeps the power saving scenario brief.
  always #2 clock = ~clock;
  dlzt_timer #(.MOD_NCK(MOD)) dlzt_timer_i (.clock(clock), .rst(rst), .req(req), .stat(stat));
  dlzt_ctrl_model dlzt_ctrl_model_i (.clock(clock), .req(req));

  // ==========================================================
  // Shared tasks
  // Case inequality so an unknown status bit never counts as a match.
  task automatic check(input string name, input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Initial calibration, with a long calibration refused while it runs.
  task automatic test_init();
    check("stat_in_reset", |stat, 1'b0);
    rst = 1'b0;
    cyc(1);
    check("init_cal_start", stat.init_cal, 1'b1);
    dlzt_ctrl_model_i.power_up();
    cyc(1010);
    check("init_cal_1015", stat.init_cal, 1'b1);
    dlzt_ctrl_model_i.send(dlzt_pkg::DLZT_CMD_ZQCL);
    cyc(19);
    check("init_cal_done", stat.init_cal, 1'b0);
    check("busy_after_init", stat.cal_busy, 1'b0);
  endtask

  // Calibration busy span; a second command during it must not stretch it.
  task automatic test_zq(input dlzt_pkg::dlzt_cmd_t cmd, input int n);
    dlzt_ctrl_model_i.send(cmd);
    cyc(2);
    check("zq_busy_start", stat.cal_busy, 1'b1);
    dlzt_ctrl_model_i.send(dlzt_pkg::DLZT_CMD_ZQCS);
    cyc(n - 4);
    check("zq_busy_late", stat.cal_busy, 1'b1);
    cyc(1);
    check("zq_busy_end", stat.cal_busy, 1'b0);
  endtask

  // Power saving entry, path close delay, refusal while closed, exit.
  task automatic test_mpsm();
    dlzt_ctrl_model_i.send(dlzt_pkg::DLZT_CMD_MPSM);
    cyc(1);
    check("mpsm_entered", stat.mpsm, 1'b1);
    cyc(int'(MOD) + 2);
    check("path_still_open", stat.cmd_path_off, 1'b0);
    cyc(1);
    check("path_closed", stat.cmd_path_off, 1'b1);
    dlzt_ctrl_model_i.send(dlzt_pkg::DLZT_CMD_ZQCL);
    cyc(3);
    check("zq_refused_off", stat.cal_busy, 1'b0);
    dlzt_ctrl_model_i.deselected_bounce();
    cyc(1);
    check("path_kept_off", stat.cmd_path_off, 1'b1);
    dlzt_ctrl_model_i.mpsm_exit();
    check("mpsm_left", stat.mpsm, 1'b0);
    check("path_reopened", stat.cmd_path_off, 1'b0);
    dlzt_ctrl_model_i.send(dlzt_pkg::DLZT_CMD_ZQCS);
    cyc(2);
    check("zq_after_exit", stat.cal_busy, 1'b1);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    cyc(4);
    test_init();
    test_zq(dlzt_pkg::DLZT_CMD_ZQCL, 512);
    test_zq(dlzt_pkg::DLZT_CMD_ZQCS, 128);
    test_mpsm();
    end_of_test();
  end
  // The whole run needs about 1700 cycles; the limit leaves a wide margin.
  initial begin
    #20000;
    bad_count++;
    $display("mismatch watchdog expected done seen hang");
    end_of_test();
  end
endmodule
